/* core_mem.sv */
// Core memory model: clocked writes, reads follow the address
module core_mem (
  input wire logic core_clk,
  input wire logic [14:0] mem_addr,
  input wire logic mem_wr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:63];
  // Address is already registered in the core, so the word reads at once
  assign mem_rdata = mem[mem_addr[5:0]];
  always @(posedge core_clk) begin
    if (mem_wr) mem[mem_addr[5:0]] <= mem_wdata;
  end
endmodule

/* cpu_core.sv */
// Processor core with memory port and operator panel
// How it works
// - Increment-and-skip reads the memory word, adds one, writes it back.
// - When that result is zero (including wrap) the next word is skipped.
// - No-operation changes nothing and just advances the program counter.
// - Complement-then-increment in one word negates the accumulator.
// - Clear-accumulator zeroes every accumulator bit.
// - Load copies the referenced word into the accumulator.
// - Store writes the accumulator to the referenced word.
// - Subroutine jump stores the return address at the target, runs on.
// - An indirect jump through that word returns to the caller.
// - Single cycle advances one phase per press; run executes freely.
// - Display memory shows the panel address word, then steps it.
// - The increment counts upward so a negative preset reaches zero.
`include "cpu_defines.svh"
module cpu_core (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  output logic [`ADDR_W-1:0] mem_addr,
  output logic mem_wr,
  output logic [`WORD_W-1:0] mem_wdata,
  input wire logic [`WORD_W-1:0] mem_rdata,
  input wire logic [`ADDR_W-1:0] panel_switches,
  input wire logic panel_load_addr,
  input wire logic panel_run,
  input wire logic panel_halt,
  input wire logic panel_single_cycle,
  input wire logic panel_display_memory,
  output logic [`WORD_W-1:0] panel_display,
  output logic [`WORD_W-1:0] accumulator,
  output logic [`ADDR_W-1:0] program_counter,
  output logic running
);
  // Panel inputs come from switches: two-stage synchronisers
  logic [4:0] pin_s1_r, pin_s2_r, pin_prev_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
      pin_prev_r <= 5'h00;
    end else if (clk_en) begin
      pin_s1_r <= {panel_display_memory, panel_single_cycle, panel_halt,
                   panel_run, panel_load_addr};
      pin_s2_r <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end
  wire [4:0] press = pin_s2_r & ~pin_prev_r;
  logic [`ADDR_W-1:0] sw_s1_r, sw_s2_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_s1_r <= `START_ADDR;
      sw_s2_r <= `START_ADDR;
    end else if (clk_en) begin
      sw_s1_r <= panel_switches;
      sw_s2_r <= sw_s1_r;
    end
  end
  wire load_press = press[0];
  wire run_press = press[1];
  wire halt_press = press[2];
  wire step_press = press[3];
  wire disp_press = press[4];

  cpu_pkg::phase_e phase_r, phase_nxt;
  logic run_r, step_r, disp_pend_r, disp_wait_r;
  logic [`ADDR_W-1:0] pc_r, pc_nxt, ma_r, ma_nxt, panel_addr_r;
  logic [`WORD_W-1:0] ir_r, ir_nxt, acc_r, acc_nxt, wd_r, wd_nxt, disp_r;
  logic wr_r, wr_nxt;

  wire [`OP_W-1:0] opcode = ir_r[`OP_LSB+`OP_W-1:`OP_LSB];
  wire [10:0] sub = ir_r[10:0];
  wire [`ADDR_W-1:0] pc_inc = pc_r + 15'h0001;
  wire [`ADDR_W-1:0] pc_skip = pc_r + 15'h0002;
  wire is_special = (opcode == `OP_SPECIAL);
  wire is_halt = is_special && (sub == `SUB_HALT);
  wire is_clear = is_special && (sub == `SUB_CLEAR);
  wire is_negate = is_special && (sub == `SUB_NEGATE);

  // Panel memory access only while stopped, one phase per operation
  wire halted = (phase_r == cpu_pkg::ST_HALT);
  wire advance = run_r || step_r;

  logic [1:0] alu_sel;
  logic [`WORD_W-1:0] alu_y;
  logic alu_zero;
  assign alu_sel = (opcode == `OP_ISZ) ? 2'h2 :
                   (opcode == `OP_ADD) ? 2'h1 :
                   is_negate ? 2'h3 : 2'h0;
  word_alu alu (
    .a(acc_r),
    .b(mem_rdata),
    .sel(alu_sel),
    .y(alu_y),
    .zero(alu_zero)
  );

  always_comb begin
    phase_nxt = phase_r;
    pc_nxt = pc_r;
    ma_nxt = ma_r;
    ir_nxt = ir_r;
    acc_nxt = acc_r;
    wd_nxt = wd_r;
    wr_nxt = 1'b0;
    case (phase_r)
      cpu_pkg::ST_HALT: begin
        ma_nxt = panel_addr_r;
        if (run_r || step_r) begin
          phase_nxt = cpu_pkg::ST_FETCH;
          ma_nxt = pc_r;
        end
      end
      cpu_pkg::ST_FETCH: begin
        ma_nxt = pc_r;
        phase_nxt = cpu_pkg::ST_DECODE;
      end
      cpu_pkg::ST_DECODE: begin
        ir_nxt = mem_rdata;
        phase_nxt = cpu_pkg::ST_EXEC;
        if (mem_rdata[14:11] != `OP_SPECIAL) begin
          ma_nxt = {pc_r[14:11], mem_rdata[10:0]};
          if (mem_rdata[`IND_BIT])
            phase_nxt = cpu_pkg::ST_INDIRECT;
        end
      end
      cpu_pkg::ST_INDIRECT: begin
        ma_nxt = mem_rdata[`ADDR_W-1:0];
        phase_nxt = cpu_pkg::ST_EXEC;
      end
      cpu_pkg::ST_EXEC: begin
        phase_nxt = cpu_pkg::ST_FETCH;
        pc_nxt = pc_inc;
        case (opcode)
          `OP_SPECIAL: begin
            if (is_clear)
              acc_nxt = 16'h0000;
            else if (is_negate)
              acc_nxt = alu_y;
            if (is_halt) begin
              phase_nxt = cpu_pkg::ST_HALT;
            end
          end
          `OP_LOAD, `OP_ADD: acc_nxt = alu_y;
          `OP_STORE: begin
            wd_nxt = acc_r;
            wr_nxt = 1'b1;
            phase_nxt = cpu_pkg::ST_WRITE;
          end
          `OP_ISZ: begin
            wd_nxt = alu_y;
            wr_nxt = 1'b1;
            phase_nxt = cpu_pkg::ST_WRITE;
            if (alu_zero)
              pc_nxt = pc_skip;
          end
          `OP_SUBJUMP: begin
            wd_nxt = {1'b0, pc_inc};
            wr_nxt = 1'b1;
            pc_nxt = ma_r + 15'h0001;
            phase_nxt = cpu_pkg::ST_WRITE;
          end
          `OP_JUMP: pc_nxt = ma_r;
          default: ;
        endcase
      end
      cpu_pkg::ST_WRITE: begin
        ma_nxt = pc_r;
        phase_nxt = cpu_pkg::ST_FETCH;
      end
      default: phase_nxt = cpu_pkg::ST_HALT;
    endcase
    // Stop at the end of a step or on halt request
    if (!halted && !run_r && phase_nxt == cpu_pkg::ST_FETCH)
      phase_nxt = cpu_pkg::ST_HALT;
    if (!halted && !advance)
      phase_nxt = phase_r;
    if (halted && !advance)
      wr_nxt = 1'b0;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= cpu_pkg::ST_HALT;
      pc_r <= `START_ADDR;
      ma_r <= `START_ADDR;
      ir_r <= 16'h0000;
      acc_r <= 16'h0000;
      wd_r <= 16'h0000;
    end else if (clk_en && (advance || halted)) begin
      phase_r <= phase_nxt;
      ma_r <= phase_nxt == cpu_pkg::ST_FETCH ? pc_nxt : ma_nxt;
      pc_r <= load_press && halted ? sw_s2_r : pc_nxt;
      ir_r <= ir_nxt;
      acc_r <= acc_nxt;
      wd_r <= wd_nxt;
    end
  end

  // Strobe drops after one cycle even when a step parks in the write phase
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      wr_r <= 1'b0;
    else if (clk_en)
      wr_r <= advance && wr_nxt;
  end

  // Run until halt; single cycle grants exactly one phase
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_r <= 1'b0;
      step_r <= 1'b0;
    end else if (clk_en) begin
      if (halt_press || (phase_r == cpu_pkg::ST_EXEC && is_halt && run_r))
        run_r <= 1'b0;
      else if (run_press)
        run_r <= 1'b1;
      step_r <= step_press && !run_r;
    end
  end

  // Display memory: address held one phase, word latched, address bumped
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      panel_addr_r <= `START_ADDR;
      disp_r <= 16'h0000;
      disp_pend_r <= 1'b0;
      disp_wait_r <= 1'b0;
    end else if (clk_en) begin
      disp_wait_r <= disp_pend_r;
      if (load_press && halted)
        panel_addr_r <= sw_s2_r;
      else if (disp_press && halted && !advance)
        disp_pend_r <= 1'b1;
      else if (disp_wait_r) begin
        disp_r <= mem_rdata;
        panel_addr_r <= panel_addr_r + 15'h0001;
        disp_pend_r <= 1'b0;
        disp_wait_r <= 1'b0;
      end
    end
  end

  assign mem_addr = ma_r;
  assign mem_wr = wr_r;
  assign mem_wdata = wd_r;
  assign panel_display = disp_r;
  assign accumulator = acc_r;
  assign program_counter = pc_r;
  assign running = run_r;
endmodule

/* cpu_core_chk.sv */
// Port-level checks for the processor core
`include "cpu_defines.svh"
module cpu_core_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic mem_wr,
  input wire logic panel_run,
  input wire logic panel_single_cycle,
  input wire logic panel_load_addr,
  input wire logic panel_display_memory,
  input wire logic [`WORD_W-1:0] panel_display,
  input wire logic [`WORD_W-1:0] accumulator,
  input wire logic [`ADDR_W-1:0] program_counter,
  input wire logic running
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idle_r;
  logic [3:0] disp_r;
  logic act;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Run press counts too: the first phase may land with the running rise
  assign act = running | panel_run | panel_single_cycle | panel_load_addr;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_r <= 4'h0;
      disp_r <= 4'h8;
    end else begin
      idle_r <= act ? 4'h0 : idle_r + 4'(!idle_r[3]);
      disp_r <= panel_display_memory ? 4'h0 : disp_r + 4'(!disp_r[3]);
    end
  end
  property p_wr_pulse; mem_wr |=> !mem_wr; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("long write");
  property p_run_go; $rose(panel_run) && !running |-> ##[2:6] running;
  endproperty
  a_run_go: assert property (p_run_go) else $error("run ignored");
  property p_run_disp; running |=> $stable(panel_display); endproperty
  a_run_disp: assert property (p_run_disp) else $error("shown in run");
  property p_idle_acc; idle_r[3] |-> $stable(accumulator); endproperty
  a_idle_acc: assert property (p_idle_acc) else $error("acc moved");
  property p_idle_pc; idle_r[3] |-> $stable(program_counter); endproperty
  a_idle_pc: assert property (p_idle_pc) else $error("pc moved");
  property p_idle_wr; idle_r[3] |-> !mem_wr; endproperty
  a_idle_wr: assert property (p_idle_wr) else $error("idle write");
  property p_disp_cause; $changed(panel_display) |-> !disp_r[3]; endproperty
  a_disp_cause: assert property (p_disp_cause) else $error("stray show");
  property p_rst_halt; $rose(reset_n) |-> !running; endproperty
  a_rst_halt: assert property (p_rst_halt) else $error("runs at reset");
  c_run: cover property ($rose(running));
  c_wr: cover property (mem_wr);
  c_show: cover property ($changed(panel_display));
endmodule
bind cpu_core cpu_core_chk cpu_core_chk_i (.core_clk, .reset_n, .mem_wr,
  .panel_run, .panel_single_cycle, .panel_load_addr, .panel_display_memory,
  .panel_display, .accumulator, .program_counter, .running);

/* cpu_defines.svh */
// Constants for the small accumulator processor core
`ifndef CPU_DEFINES_SVH
`define CPU_DEFINES_SVH
`define WORD_W 16
`define ADDR_W 15
`define OP_LSB 11
`define OP_W 4
`define IND_BIT 15
`define OP_SPECIAL 4'h0
`define OP_SUBJUMP 4'h1
`define OP_JUMP 4'h2
`define OP_ISZ 4'h3
`define OP_ADD 4'h4
`define OP_LOAD 4'h6
`define OP_STORE 4'h7
`define SUB_NOP 11'h000
`define SUB_CLEAR 11'h100
`define SUB_NEGATE 11'h001
`define SUB_HALT 11'h400
`define START_ADDR 15'h0000
`endif

/* cpu_pkg.sv */
// Types shared by the processor core
package cpu_pkg;
  typedef enum logic [2:0] {
    ST_HALT, ST_FETCH, ST_DECODE, ST_INDIRECT, ST_EXEC, ST_WRITE
  } phase_e;
endpackage

/* testbench.sv */
// Counting program run on the core, results read back on the panel
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0;
  logic reset_n = 0;
  logic show = 0;
  logic [4:0] btn = '0;
  logic [14:0] sw = '0;
  logic [14:0] mem_addr, program_counter;
  logic mem_wr, running;
  logic [15:0] mem_wdata, mem_rdata, panel_display, accumulator, y, sub;
  logic [15:0] exp_q[$];
  logic [15:0] prog [26];
  logic [15:0] rd [7];
  int n;
  int seed = 32'h11daa0c8;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  always #12.5 core_clk = ~core_clk;
  cpu_core cpu_core_i (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
    .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .panel_switches(sw), .panel_load_addr(btn[0]),
    .panel_run(btn[1]), .panel_halt(btn[2]), .panel_single_cycle(btn[3]),
    .panel_display_memory(btn[4]), .panel_display(panel_display),
    .accumulator(accumulator), .program_counter(program_counter),
    .running(running));
  core_mem core_mem_i (.core_clk(core_clk), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
      miscompares++;
    end
  endtask
  task automatic final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Held 2 cycles, then quiet long enough for sync and edge detect
  task automatic press(input int b);
    @(negedge core_clk) btn[b] = 1'b1;
    repeat (2) @(negedge core_clk);
    btn[b] = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask
  task automatic disp(input logic [15:0] e);
    exp_q.push_back(e);
    press(4);
    show = 1'b1;
    @(negedge core_clk) show = 1'b0;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (show) cmp(panel_display, exp_q.pop_front());
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    n = 1 + $unsigned($random(seed)) % 6;
    y = 16'($random(seed));
    sub = 16'h0005 + y * 16'(n);
    // Counter and tally start dirty so the initialization must overwrite them
    prog = '{16'h3013, 16'h0001, 16'h3814, 16'h0100, 16'h3815, 16'h3016,
      16'h1815, 16'h0000, 16'h2017, 16'h1814, 16'h1006, 16'h3818, 16'h080e,
      16'h0400, 16'h0000, 16'h3018, 16'h2016, 16'h3819, 16'h900e, 16'(n),
      16'h0055, 16'h00ff, 16'h0005, y, 16'h0000, 16'h0000};
    rd = '{16'(n), 16'h0000, 16'(n), 16'h0005, y, sub, sub + 16'h0005};
    for (int i = 0; i < 26; i++) core_mem_i.mem[i] = prog[i];
    repeat (20) @(negedge core_clk);
    reset_n = 1'b1;
    press(0);
    press(1);
    while (running === 1'b1) @(negedge core_clk);
    cmp(accumulator, sub + 16'h0005);
    // Rerun: single cycle through load and negate, then run, halt, resume
    sw = 15'h0000;
    press(0);
    repeat (3) press(3);
    cmp(accumulator, sub + 16'h0005);
    press(3);
    cmp(accumulator, 16'(n));
    repeat (3) press(3);
    cmp(16'(program_counter), 16'h0001);
    press(3);
    cmp(accumulator, 16'h0000 - 16'(n));
    press(1);
    press(2);
    cmp(16'(running), 16'h0000);
    repeat (4) @(negedge core_clk);
    press(1);
    while (running === 1'b1) @(negedge core_clk);
    cmp(accumulator, sub + 16'h0005);
    sw = 15'h0013;
    press(0);
    foreach (rd[i]) disp(rd[i]);
    sw = 15'h000e;
    press(0);
    disp(16'h000d);
    final_report();
  end
endmodule

/* word_alu.sv */
// Accumulator arithmetic unit
`include "cpu_defines.svh"
module word_alu (
  input wire logic [`WORD_W-1:0] a,
  input wire logic [`WORD_W-1:0] b,
  input wire logic [1:0] sel,
  output logic [`WORD_W-1:0] y,
  output logic zero
);
  // 0 pass b, 1 a+b, 2 b+1, 3 negate a
  always_comb begin
    case (sel)
      2'h0: y = b;
      2'h1: y = a + b;
      2'h2: y = b + 16'h0001;
      default: y = (~a) + 16'h0001;
    endcase
    zero = (y == 16'h0000);
  end
endmodule
